// File: rtl/dbm_bus_if.sv
// Purpose: bus master and slave logic of a disk controller on an async handshaked bus
// Assumes: arbitration happens outside; microprogram actions arrive as APB writes
// Notes: go and terminate are open-drain, asserted while their enable is high; go is seen low, terminate high
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module dbm_bus_if (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dbm_pkg::dbm_bus_in_t bus_in,
  input wire logic chassis_id,
  input wire logic [3:0] base_switch,
  output dbm_pkg::dbm_bus_out_t bus_out,
  output logic trap_pulse,
  output logic [7:0] trap_vector,
  output logic micro_clock_stop,
  output logic bus_error_latched_n,
  output logic master_timeout_n
);
  dbm_pkg::dbm_state_t st;
  dbm_pkg::dbm_bus_in_t bin;
  logic chassis_s;
  logic [3:0] sw_s;
  logic master_active_ff, device_access_ff, master_go_ff;
  logic latched_write_bit;
  logic [2:0] latched_source_field;
  logic master_terminate, term_seen;
  logic [10:0] tmo_cnt;
  logic bus_err, tmo_err;
  logic [15:0] addr_lo, array_data, fifo_data, internal_proc_bus, slv_rdata;
  logic [3:0] msb_cnt;
  logic cfg_write, slave_en, busy;
  logic [2:0] cfg_src;
  logic [4:0] go_cnt;
  logic slv_xfer, slv_wr, slv_term, busy_term, slv_b;
  logic [31:0] rd_mux;
  logic hit;

  dbm_sync #(.W($bits(dbm_pkg::dbm_bus_in_t) + 5), .RST({5'h00, dbm_pkg::BUS_IN_IDLE})) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({chassis_id, base_switch, bus_in}),
    .q({chassis_s, sw_s, bin})
  );

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite & ~pslverr;
  wire wr_ctrl = wr & (paddr == dbm_pkg::OFF_CTRL);
  wire wr_stat = wr & (paddr == dbm_pkg::OFF_STATUS);
  wire cmd_start = wr_ctrl & pwdata[dbm_pkg::CB_START];
  wire cmd_inc = wr_ctrl & pwdata[dbm_pkg::CB_MSBINC];
  wire cmd_sterm = wr_ctrl & pwdata[dbm_pkg::CB_SLVTERM];

  always_comb begin
    hit = 1'b1;
    case (paddr)
      dbm_pkg::OFF_CTRL: rd_mux = {25'h0, busy, slave_en, cfg_src, cfg_write, 1'b0};
      dbm_pkg::OFF_ADDR: rd_mux = {12'h0, msb_cnt, addr_lo};
      dbm_pkg::OFF_ARRAY: rd_mux = {16'h0, array_data};
      dbm_pkg::OFF_FIFO: rd_mux = {16'h0, fifo_data};
      dbm_pkg::OFF_PBUS: rd_mux = {16'h0, internal_proc_bus};
      dbm_pkg::OFF_STATUS: rd_mux = {24'h0, master_go_ff, chassis_s, slv_wr, slv_xfer,
                                     tmo_err, bus_err, device_access_ff, master_active_ff};
      dbm_pkg::OFF_SLVRD: rd_mux = {16'h0, slv_rdata};
      dbm_pkg::OFF_TRAP: rd_mux = {24'h0, trap_vector};
      default: begin
        rd_mux = dbm_pkg::RST_WORD;
        hit = 1'b0;
      end
    endcase
  end

  // one wait-free access cycle; answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= dbm_pkg::RST_WORD;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? rd_mux : dbm_pkg::RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_write <= 1'b0;
      cfg_src <= 3'h0;
      slave_en <= 1'b0;
      busy <= 1'b0;
      addr_lo <= 16'h0;
      msb_cnt <= 4'h0;
      array_data <= 16'h0;
      fifo_data <= 16'h0;
      slv_rdata <= 16'h0;
    end else begin
      if (wr_ctrl) begin
        cfg_write <= pwdata[dbm_pkg::CB_WRITE];
        cfg_src <= pwdata[dbm_pkg::CB_SRC +: 3];
        slave_en <= pwdata[dbm_pkg::CB_SLVEN];
        busy <= pwdata[dbm_pkg::CB_BUSY];
      end
      if (wr & (paddr == dbm_pkg::OFF_ADDR)) begin
        addr_lo <= pwdata[15:0];
        msb_cnt <= pwdata[19:16];
      end else if (cmd_inc) begin
        msb_cnt <= 4'(msb_cnt + 4'h1);
      end
      if (wr & (paddr == dbm_pkg::OFF_ARRAY)) array_data <= pwdata[15:0];
      if (wr & (paddr == dbm_pkg::OFF_FIFO)) fifo_data <= pwdata[15:0];
      if (wr & (paddr == dbm_pkg::OFF_SLVRD)) slv_rdata <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // master sequence
  // ----------------------------------------------------------------
  // own go is not on the bus yet while waiting, so any go seen is foreign
  wire go_inhibit = ~bin.go_n | bin.term;
  wire mt_en = chassis_s ? device_access_ff : master_go_ff;
  wire mt_now = (st == dbm_pkg::ST_ACCESS) & bin.term & mt_en;
  wire mt_rise = mt_now & ~master_terminate;
  wire mt_fall = master_terminate & ~mt_now;
  wire tmo_hit = (tmo_cnt == dbm_pkg::TMO_LAST) & ~mt_now;
  wire mst_busy = (st == dbm_pkg::ST_GOWAIT) | (st == dbm_pkg::ST_ACCESS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt <= 11'h0;
    end else if (~mst_busy | bin.wait_req) begin
      tmo_cnt <= 11'h0;
    end else if (tmo_cnt != dbm_pkg::TMO_LAST) begin
      tmo_cnt <= 11'(tmo_cnt + 11'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= dbm_pkg::ST_IDLE;
      master_active_ff <= 1'b0;
      device_access_ff <= 1'b0;
      master_go_ff <= 1'b0;
      latched_write_bit <= 1'b0;
      latched_source_field <= 3'h0;
      master_terminate <= 1'b0;
      term_seen <= 1'b0;
    end else begin
      master_terminate <= mt_now;
      case (st)
        dbm_pkg::ST_IDLE: begin
          if (cmd_start) begin
            master_active_ff <= 1'b1;
            device_access_ff <= 1'b1;
            latched_write_bit <= pwdata[dbm_pkg::CB_WRITE];
            latched_source_field <= pwdata[dbm_pkg::CB_SRC +: 3];
            term_seen <= 1'b0;
            st <= dbm_pkg::ST_GOWAIT;
          end
        end
        dbm_pkg::ST_GOWAIT: begin
          if (tmo_hit) begin
            master_active_ff <= 1'b0;
            device_access_ff <= 1'b0;
            st <= dbm_pkg::ST_IDLE;
          end else if (~go_inhibit) begin
            master_go_ff <= 1'b1;
            st <= dbm_pkg::ST_ACCESS;
          end
        end
        dbm_pkg::ST_ACCESS: begin
          // go_inhibit is not looked at here any more
          if (mt_rise) begin
            master_go_ff <= 1'b0;
            term_seen <= 1'b1;
          end
          if (mt_fall & ~chassis_s) begin
            master_active_ff <= 1'b0;
            device_access_ff <= 1'b0;
            st <= dbm_pkg::ST_IDLE;
          end else if (mt_fall) begin
            device_access_ff <= 1'b0;
            st <= dbm_pkg::ST_RELEASE;
          end else if (tmo_hit) begin
            master_go_ff <= 1'b0;
            master_active_ff <= 1'b0;
            device_access_ff <= 1'b0;
            st <= dbm_pkg::ST_IDLE;
          end
        end
        dbm_pkg::ST_RELEASE: begin
          master_active_ff <= 1'b0;
          st <= dbm_pkg::ST_IDLE;
        end
        default: st <= dbm_pkg::ST_IDLE;
      endcase
    end
  end

  // sticky errors; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_err <= 1'b0;
      tmo_err <= 1'b0;
    end else begin
      if (mt_rise & ~latched_write_bit & ~bin.parity_err_n) bus_err <= 1'b1;
      else if (wr_stat & pwdata[dbm_pkg::SB_BUSERR]) bus_err <= 1'b0;
      if (mst_busy & tmo_hit) tmo_err <= 1'b1;
      else if (wr_stat & pwdata[dbm_pkg::SB_TMO]) tmo_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // slave side
  // ----------------------------------------------------------------
  logic [19:0] base;
  always_comb begin
    base = dbm_pkg::BASE_FIXED;
    if (sw_s[0]) base = base | dbm_pkg::SW1_ADD;
    if (sw_s[1]) base = base | dbm_pkg::SW2_ADD;
    if (sw_s[2]) base = base | dbm_pkg::SW3_ADD;
    if (sw_s[3]) base = base | dbm_pkg::SW4_ADD;
  end
  wire slave_addr_match = bin.addr[19:3] == base[19:3];
  wire go_act = ~bin.go_n & ~device_access_ff;
  wire slv_evt = go_act & ~slv_xfer & (go_cnt == dbm_pkg::SLV_GO_LAST) & slave_addr_match;
  wire slv_ok = slave_en & ~busy & ~slv_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_cnt <= 5'h0;
      slv_xfer <= 1'b0;
      slv_wr <= 1'b0;
      slv_term <= 1'b0;
      busy_term <= 1'b0;
    end else if (~go_act) begin
      go_cnt <= 5'h0;
      slv_xfer <= 1'b0;
      slv_term <= 1'b0;
      busy_term <= 1'b0;
    end else begin
      if (go_cnt != dbm_pkg::SLV_GO_LAST) go_cnt <= 5'(go_cnt + 5'h1);
      if (slv_evt) begin
        slv_xfer <= 1'b1;
        slv_wr <= ~bin.read_dir;
        busy_term <= ~slv_ok;
      end
      if (cmd_sterm & slv_xfer & ~busy_term) slv_term <= 1'b1;
    end
  end

  // the internal bus register holds master read data or slave write data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_proc_bus <= 16'h0;
    end else if (mt_rise & ~latched_write_bit) begin
      internal_proc_bus <= bin.data;
    end else if (slv_evt & slv_ok & ~bin.read_dir) begin
      internal_proc_bus <= bin.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pulse <= 1'b0;
      trap_vector <= 8'h0;
      slv_b <= 1'b0;
    end else begin
      trap_pulse <= slv_evt & slv_ok;
      slv_b <= trap_pulse;
      if (slv_evt & slv_ok) begin
        trap_vector <= dbm_pkg::TRAP_BASE | {4'h0, ~bin.read_dir, bin.addr[2:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [15:0] wdata_mux;
  always_comb begin
    case (latched_source_field)
      dbm_pkg::SRC_ARRAY: wdata_mux = array_data;
      dbm_pkg::SRC_FIFO: wdata_mux = fifo_data;
      dbm_pkg::SRC_BUSIN: wdata_mux = internal_proc_bus;
      default: wdata_mux = 16'h0;
    endcase
  end
  wire access_strobe = st == dbm_pkg::ST_ACCESS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_out <= '0;
      micro_clock_stop <= 1'b0;
      bus_error_latched_n <= 1'b1;
      master_timeout_n <= 1'b1;
    end else begin
      bus_out.go_oe <= access_strobe & master_go_ff & ~mt_rise & ~tmo_hit;
      bus_out.dir_oe <= access_strobe;
      bus_out.read_dir <= ~latched_write_bit;
      bus_out.addr_oe <= access_strobe;
      bus_out.addr <= {msb_cnt, addr_lo};
      bus_out.term_oe <= slv_term | busy_term;
      if (access_strobe & latched_write_bit & ~term_seen & ~mt_rise) begin
        bus_out.data_oe <= 16'hffff;
        bus_out.data <= wdata_mux;
      end else if (slv_term & ~slv_wr) begin
        bus_out.data_oe <= 16'hffff;
        bus_out.data <= slv_rdata;
      end else if (busy_term & ~slv_wr) begin
        bus_out.data_oe <= 16'h0001;
        bus_out.data <= 16'h0000;
      end else begin
        bus_out.data_oe <= 16'h0000;
        bus_out.data <= 16'h0000;
      end
      micro_clock_stop <= master_active_ff;
      bus_error_latched_n <= ~bus_err;
      master_timeout_n <= ~tmo_err;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ch2_release;
    mt_fall && chassis_s ##1 (!device_access_ff && master_active_ff) ##1 !master_active_ff;
  endsequence
  sequence s_trap_once;
    trap_pulse ##1 !trap_pulse;
  endsequence

  property p_go_inhibit;
    st == dbm_pkg::ST_GOWAIT && go_inhibit |=> !master_go_ff;
  endproperty
  a_go_inhibit: assert property (p_go_inhibit) else $error("go latched while bus busy");
  property p_go_hold;
    access_strobe && master_go_ff && !mt_now && !tmo_hit |=> master_go_ff;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("go dropped early");
  property p_dir;
    access_strobe |=> bus_out.dir_oe && bus_out.read_dir == !latched_write_bit;
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_rd_nodrive;
    access_strobe && !latched_write_bit && !slv_xfer |=> bus_out.data_oe == 16'h0000;
  endproperty
  a_rd_nodrive: assert property (p_rd_nodrive) else $error("data driven on read");
  property p_term_go;
    mt_rise |=> !master_go_ff ##1 !bus_out.go_oe;
  endproperty
  a_term_go: assert property (p_term_go) else $error("go not cleared");
  property p_parity;
    mt_rise && !latched_write_bit && !bin.parity_err_n |=> bus_err ##1 !bus_error_latched_n;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error lost");
  property p_ch1;
    mt_fall && !chassis_s |=> !master_active_ff && !device_access_ff;
  endproperty
  a_ch1: assert property (p_ch1) else $error("type one release wrong");
  property p_ch2;
    mt_fall && chassis_s |-> s_ch2_release;
  endproperty
  a_ch2: assert property (p_ch2) else $error("type two release wrong");
  property p_trap;
    trap_pulse |-> s_trap_once;
  endproperty
  a_trap: assert property (p_trap) else $error("trap too long");
  property p_slv_delay;
    $rose(slv_xfer) |-> $past(go_cnt) == dbm_pkg::SLV_GO_LAST && $past(go_act, 20);
  endproperty
  a_slv_delay: assert property (p_slv_delay) else $error("slave go delay short");
  property p_lock;
    $rose(trap_pulse) |-> $past(slave_en) && !$past(busy);
  endproperty
  a_lock: assert property (p_lock) else $error("trap while not idle");
  property p_clk;
    master_active_ff |=> micro_clock_stop;
  endproperty
  a_clk: assert property (p_clk) else $error("clock not stopped");
endmodule

// File: rtl/dbm_pkg.sv
// Purpose: constants and types shared by the disk bus master/slave block
// Assumes: pclk at 200 MHz, APB register access
// Notes: byte offsets are APB byte addresses
package dbm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int SLV_GO_NS = 100;
  localparam int SLV_GO_CYC = (SLV_GO_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] SLV_GO_LAST = 5'(SLV_GO_CYC - 1);
  localparam int TMO_NS = 10000;
  localparam int TMO_CYC = TMO_NS / CLK_NS;
  localparam logic [10:0] TMO_LAST = 11'(TMO_CYC - 1);
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_ARRAY = 8'h08;
  localparam logic [7:0] OFF_FIFO = 8'h0c;
  localparam logic [7:0] OFF_PBUS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_SLVRD = 8'h18;
  localparam logic [7:0] OFF_TRAP = 8'h1c;
  localparam int CB_START = 0;
  localparam int CB_WRITE = 1;
  localparam int CB_SRC = 2;
  localparam int CB_SLVEN = 5;
  localparam int CB_BUSY = 6;
  localparam int CB_MSBINC = 8;
  localparam int CB_SLVTERM = 9;
  localparam int SB_BUSERR = 2;
  localparam int SB_TMO = 3;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // idle pin levels: go and parity error released, data pulled up
  localparam logic [40:0] BUS_IN_IDLE = {1'b1, 3'h0, 1'b1, 20'h00000, 16'hffff};
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_ARRAY = 3'h1;
  localparam logic [2:0] SRC_BUSIN = 3'h3;
  localparam logic [2:0] SRC_FIFO = 3'h4;
  localparam logic [19:0] BASE_FIXED = 20'hffc00;
  localparam logic [19:0] SW1_ADD = 20'h00010;
  localparam logic [19:0] SW2_ADD = 20'h00020;
  localparam logic [19:0] SW3_ADD = 20'h00040;
  localparam logic [19:0] SW4_ADD = 20'h00008;
  localparam logic [7:0] TRAP_BASE = 8'hf0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_GOWAIT = 4'h2,
    ST_ACCESS = 4'h4,
    ST_RELEASE = 4'h8
  } dbm_state_t;
  typedef struct packed {
    logic go_n;
    logic term;
    logic read_dir;
    logic wait_req;
    logic parity_err_n;
    logic [19:0] addr;
    logic [15:0] data;
  } dbm_bus_in_t;
  typedef struct packed {
    logic go_oe;
    logic term_oe;
    logic dir_oe;
    logic read_dir;
    logic addr_oe;
    logic [19:0] addr;
    logic [15:0] data_oe;
    logic [15:0] data;
  } dbm_bus_out_t;
endpackage

// File: rtl/dbm_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module dbm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// File: tb/dbm_far_model.sv
// Purpose: far side of the disk bus, a memory slave plus a remote master
// Assumes: bench sets mute, perr and rdata between cycles
// Notes: released address and direction lines show the remote values while remote go is on and inverted otherwise, undriven data lines read all ones
`timescale 1ns/1ps
module dbm_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire dbm_pkg::dbm_bus_out_t bus_out,
  output dbm_pkg::dbm_bus_in_t bus_in
);
  logic mute = 1'b0;
  logic perr = 1'b0;
  int dly = 3;
  logic [15:0] rdata = 16'h0000;
  logic rgo = 1'b0;
  logic rdir = 1'b0;
  logic [19:0] raddr = 20'h00000;
  logic [15:0] rdat = 16'h0000;
  logic term = 1'b0;
  int cnt = 0;
  // terminate some cycles after go, released only once go is gone
  always @(posedge pclk) begin
    if (bus_out.go_oe && !mute) begin
      cnt <= cnt + 1;
      if (cnt == dly) term <= 1'b1;
    end else begin
      cnt <= 0;
      term <= 1'b0;
    end
  end
  always_comb begin
    bus_in.go_n = !(bus_out.go_oe || rgo);
    bus_in.term = term || bus_out.term_oe;
    bus_in.read_dir = bus_out.dir_oe ? bus_out.read_dir : (rgo ? rdir : !rdir);
    bus_in.wait_req = 1'b0;
    bus_in.parity_err_n = !(perr && term);
    bus_in.addr = bus_out.addr_oe ? bus_out.addr : (rgo ? raddr : ~raddr);
    // data lines are pulled up where nobody drives
    bus_in.data = (bus_out.data & bus_out.data_oe) | (~bus_out.data_oe &
      (term && bus_out.read_dir ? rdata : (rgo && !rdir ? rdat : 16'hffff)));
  end
  task automatic go_on(input logic r, input logic [19:0] a, input logic [15:0] d);
    @(posedge pclk);
    rdir <= r;
    raddr <= a;
    rdat <= d;
    rgo <= 1'b1;
  endtask
  task automatic go_off();
    @(posedge pclk);
    rgo <= 1'b0;
  endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the disk bus master/slave block
// Assumes: far side given by dbm_far_model, switches give base ffc18
// Notes: every wait except the APB ready loop is bounded and its bound is checked
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dbm_pkg::dbm_bus_in_t bus_in;
  dbm_pkg::dbm_bus_out_t bus_out;
  logic chassis_id = 1'b0;
  logic [3:0] base_switch = 4'h9;
  logic trap_pulse;
  logic [7:0] trap_vector;
  logic micro_clock_stop;
  logic bus_error_latched_n;
  logic master_timeout_n;
  logic [31:0] rd;
  logic se;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  always #2.5 pclk = ~pclk;
  dbm_bus_if i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_in(bus_in), .chassis_id(chassis_id), .base_switch(base_switch), .bus_out(bus_out),
    .trap_pulse(trap_pulse), .trap_vector(trap_vector), .micro_clock_stop(micro_clock_stop),
    .bus_error_latched_n(bus_error_latched_n), .master_timeout_n(master_timeout_n));
  dbm_far_model i_far (.pclk(pclk), .presetn(presetn), .bus_out(bus_out), .bus_in(bus_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic idle_wait();
    n = 0;
    while (micro_clock_stop !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 60, 1);
  endtask
  task automatic go_wait();
    n = 0;
    while (bus_out.go_oe !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 60, 1);
  endtask
  task automatic t_mwrite();
    apb(1'b1, 8'h04, 32'h00035678);
    apb(1'b1, 8'h08, 32'h0000abcd);
    apb(1'b1, 8'h00, 32'h00000007);
    go_wait();
    chk(bus_out.addr, 32'h35678);
    chk({bus_out.addr_oe, bus_out.dir_oe, bus_out.read_dir, micro_clock_stop}, 4'hd);
    chk({bus_out.data_oe, bus_out.data}, 32'hffffabcd);
    idle_wait();
    chk(n < 60, 1);
    repeat (3) @(posedge pclk);
    chk({bus_out.go_oe, bus_out.addr_oe, bus_out.data_oe}, 0);
    apb(1'b1, 8'h0c, 32'h00001357);
    apb(1'b1, 8'h00, 32'h00000113);
    go_wait();
    chk(bus_out.addr, 32'h45678);
    chk({bus_out.data_oe, bus_out.data}, 32'hffff1357);
    idle_wait();
  endtask
  task automatic t_mread();
    chassis_id <= 1'b1;
    i_far.perr <= 1'b1;
    i_far.rdata <= 16'h2b4e;
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0000000d);
    go_wait();
    chk({bus_out.data_oe, bus_out.dir_oe, bus_out.read_dir}, 18'h00003);
    idle_wait();
    chk(bus_in.term, 0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h2b4e);
    chk(bus_error_latched_n, 0);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[2], bus_error_latched_n}, 2'b01);
    i_far.perr <= 1'b0;
    chassis_id <= 1'b0;
  endtask
  task automatic t_inhibit();
    i_far.go_on(1'b1, 20'hffc05, 16'h0000);
    repeat (30) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h00000007);
    repeat (20) @(posedge pclk);
    chk({bus_out.go_oe, bus_out.term_oe, trap_pulse}, 0);
    i_far.go_off();
    go_wait();
    chk(n < 60, 1);
    idle_wait();
  endtask
  task automatic t_timeout();
    i_far.mute <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000000d);
    n = 0;
    while (master_timeout_n !== 1'b0 && n < 2100) begin
      @(posedge pclk);
      n++;
    end
    chk(n > 1980 && n < 2100, 1);
    repeat (3) @(posedge pclk);
    chk({micro_clock_stop, bus_out.go_oe}, 0);
    i_far.mute <= 1'b0;
    apb(1'b1, 8'h14, 32'h8);
  endtask
  task automatic slave_cycle(input logic r, input logic [19:0] a, input logic [15:0] d, input logic [7:0] v);
    i_far.go_on(r, a, d);
    n = 0;
    while (trap_pulse !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 20 && n < 60, 1);
    chk(trap_vector, v);
    @(posedge pclk);
    chk(trap_pulse, 0);
    apb(1'b1, 8'h18, {16'h0000, d});
    apb(1'b1, 8'h00, 32'h00000220);
    n = 0;
    while (bus_out.term_oe !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(bus_out.term_oe, 1);
    if (r) chk({bus_out.data_oe, bus_out.data}, {16'hffff, d});
    i_far.go_off();
    repeat (5) @(posedge pclk);
    chk(bus_out.term_oe, 0);
    apb(1'b0, 8'h10, 32'h0);
    if (!r) chk(rd, {16'h0000, d});
  endtask
  task automatic t_busy();
    apb(1'b1, 8'h00, 32'h00000040);
    i_far.go_on(1'b1, 20'hffc1a, 16'h0000);
    n = 0;
    while (bus_out.term_oe !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk({bus_out.term_oe, bus_out.data_oe[0], bus_out.data[0], trap_pulse}, 4'b1100);
    i_far.go_off();
    repeat (5) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(se, 1);
    chk(rd, 0);
    t_mwrite();
    t_mread();
    t_inhibit();
    t_timeout();
    apb(1'b1, 8'h00, 32'h00000020);
    slave_cycle(1'b1, 20'hffc1d, 16'h1234, 8'hf5);
    slave_cycle(1'b0, 20'hffc1a, 16'h5a5a, 8'hfa);
    t_busy();
    report_and_stop();
  end
endmodule
